// File: logic/min_pulse_width_params.svh
`ifndef MIN_PULSE_WIDTH_PARAMS_SVH
`define MIN_PULSE_WIDTH_PARAMS_SVH

// Register word indices on the Avalon-MM word address.
`define MIN_PULSE_WIDTH_REG_CTRL        4'h0
`define MIN_PULSE_WIDTH_REG_PERIOD      4'h1
`define MIN_PULSE_WIDTH_REG_DUTY_A      4'h2
`define MIN_PULSE_WIDTH_REG_DUTY_B      4'h3
`define MIN_PULSE_WIDTH_REG_DUTY_C      4'h4
`define MIN_PULSE_WIDTH_REG_DEAD        4'h5
`define MIN_PULSE_WIDTH_REG_MINPW       4'h6
`define MIN_PULSE_WIDTH_REG_SEG         4'h7
`define MIN_PULSE_WIDTH_REG_STATUS      4'h8
`define MIN_PULSE_WIDTH_REG_SEG_ACTIVE  4'h9

// Control register fields.
`define MIN_PULSE_WIDTH_CTRL_ENABLE_BIT 0
`define MIN_PULSE_WIDTH_CTRL_DOUBLE_BIT 1

// Segment register fields.
`define MIN_PULSE_WIDTH_SEG_XOVER_A_BIT 8
`define MIN_PULSE_WIDTH_SEG_DIS_AH_BIT  4
`define MIN_PULSE_WIDTH_SEG_DIS_AL_BIT  5

// Field widths.
`define MIN_PULSE_WIDTH_CNT_W           16
`define MIN_PULSE_WIDTH_DEAD_W          10
`define MIN_PULSE_WIDTH_MINPW_W         10
`define MIN_PULSE_WIDTH_SEG_W           9

// Reset values.
`define MIN_PULSE_WIDTH_CTRL_RST        2'h0
`define MIN_PULSE_WIDTH_PERIOD_RST      16'h0000
`define MIN_PULSE_WIDTH_DUTY_RST        16'h0000
`define MIN_PULSE_WIDTH_DEAD_RST        10'h000
`define MIN_PULSE_WIDTH_MINPW_RST       10'h000
`define MIN_PULSE_WIDTH_SEG_RST         9'h000

`endif

// File: logic/min_pulse_width_pkg.sv
package min_pulse_width_pkg;

    typedef enum logic {
        MIN_PULSE_WIDTH_IDLE,
        MIN_PULSE_WIDTH_RUN
    } min_pulse_width_state_t;

    typedef logic [15:0] min_pulse_width_count_t;

endpackage

// File: logic/min_pulse_width_out_stage.sv
`timescale 1ns/1ps
`include "min_pulse_width_params.svh"

module min_pulse_width_out_stage
    import min_pulse_width_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        nrst,
    input  wire logic [2:0]  raw_high,
    input  wire logic [2:0]  raw_low,
    input  wire logic [8:0]  seg,
    output logic      [2:0]  pin_high_q,
    output logic      [2:0]  pin_low_q
);

    logic [2:0] pin_high_d;
    logic [2:0] pin_low_d;

    genvar p;
    generate
        for (p = 0; p < 3; p++) begin : g_pair
            logic xover;
            assign xover = seg[`MIN_PULSE_WIDTH_SEG_XOVER_A_BIT - p];
            // Disable gates the pins after the swap, so it always names the physical pin.
            assign pin_high_d[p] = (xover ? raw_low[p] : raw_high[p]) &
                                   ~seg[`MIN_PULSE_WIDTH_SEG_DIS_AH_BIT - 2 * p];
            assign pin_low_d[p]  = (xover ? raw_high[p] : raw_low[p]) &
                                   ~seg[`MIN_PULSE_WIDTH_SEG_DIS_AL_BIT - 2 * p];
        end
    endgenerate

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            pin_high_q <= 3'h0;
            pin_low_q  <= 3'h0;
        end else begin
            pin_high_q <= pin_high_d;
            pin_low_q  <= pin_low_d;
        end
    end

endmodule

// File: logic/min_pulse_width_top.sv
// Operation
// - Single update: one duty set serves both halves, step is two clocks.
// - Double update: each half latches its own duty, step is one clock.
// - Programmable minimum on-time in clock periods, per output, per half.
// - Short output forced off for the half, its complement fully on.
// - Minimum check uses duty minus dead time for high, period minus duty minus dead time for low.
// - One 9-bit read/write segment register holds crossover and disables.
// - Bit 8 crosses pair A, bit 7 pair B, bit 6 pair C.
// - Crossover routes high-side to low pin and low-side to high pin.
// - Crossover bits reset to zero.
// - Bits 0 to 5 each force one output off while set.
// - Bits 0 and 1 disable phase C high and low outputs.
// - Disable gates pins after the crossover swap.
// - Disable bits reset to zero.
// - Segment writes apply only at sync: period start, plus mid-period in double.
// - Minimum width field reaches 51 us in 50 ns steps at 20 MHz.
// - Dead time reaches 51 us in 50 ns steps at 20 MHz.
// - Duty sets high on-time per half; each edge moves by dead time.
// - Double update adds mid-period sync; all settings latch there.
`timescale 1ns/1ps
`include "min_pulse_width_params.svh"

module min_pulse_width_top
    import min_pulse_width_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        nrst,
    input  wire logic [3:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    output logic             period_sync_pulse,
    output logic             phase_a_high,
    output logic             phase_a_low,
    output logic             phase_b_high,
    output logic             phase_b_low,
    output logic             phase_c_high,
    output logic             phase_c_low
);

    function automatic logic [31:0] be_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  be);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[8*i +: 8] = new_v[8*i +: 8];
            end
        end
        return r;
    endfunction

    // Saturating a - b - c, so negative on-times clamp to zero.
    function automatic logic [16:0] sat_sub(input logic [16:0] a,
                                            input logic [16:0] b,
                                            input logic [16:0] c);
        logic [17:0] s;
        s = {1'b0, b} + {1'b0, c};
        return ({1'b0, a} > s) ? 17'({1'b0, a} - s) : 17'h00000;
    endfunction

    // Window of length on_t inside a half of length t_len, at its start or end.
    function automatic logic in_window(input logic [16:0] cnt,
                                       input logic [16:0] t_len,
                                       input logic [16:0] on_t,
                                       input logic        at_end);
        logic [17:0] sum;
        sum = {1'b0, cnt} + {1'b0, on_t};
        return at_end ? (sum >= {1'b0, t_len}) : (cnt < on_t);
    endfunction

    // Bus-visible registers.
    logic [1:0]                  ctrl_q;
    min_pulse_width_count_t                period_q;
    min_pulse_width_count_t                duty_q [3];
    logic [`MIN_PULSE_WIDTH_DEAD_W-1:0]    dead_q;
    logic [`MIN_PULSE_WIDTH_MINPW_W-1:0]   minpw_q;
    logic [`MIN_PULSE_WIDTH_SEG_W-1:0]     seg_q;

    // Shadow copies that the timing logic actually uses.
    min_pulse_width_count_t                period_sh_q;
    min_pulse_width_count_t                duty_sh_q [3];
    logic [`MIN_PULSE_WIDTH_DEAD_W-1:0]    dead_sh_q;
    logic [`MIN_PULSE_WIDTH_MINPW_W-1:0]   minpw_sh_q;
    logic [`MIN_PULSE_WIDTH_SEG_W-1:0]     seg_sh_q;

    min_pulse_width_state_t                state_q;
    min_pulse_width_count_t                cnt_q;
    logic                        half_q;
    logic                        sync_q;
    logic [5:0]                  deleted_q;

    logic                        wait_q;
    logic [31:0]                 rdata_q;
    logic                        req;
    logic                        wr_take;
    logic                        run_start;
    logic                        half_end;
    logic                        latch_now;
    logic [2:0]                  raw_high;
    logic [2:0]                  raw_low;
    logic [5:0]                  deleted_d;
    logic [2:0]                  pin_high_q;
    logic [2:0]                  pin_low_q;

    assign req     = avs_read | avs_write;
    assign wr_take = avs_write & ~wait_q;

    // Bus slave: one wait cycle per request, then a single ready cycle.
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            wait_q <= 1'b1;
        end else begin
            wait_q <= ~(req & wait_q);
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            rdata_q <= 32'h00000000;
        end else if (avs_read && wait_q) begin
            case (avs_address)
                `MIN_PULSE_WIDTH_REG_CTRL:       rdata_q <= {30'h0, ctrl_q};
                `MIN_PULSE_WIDTH_REG_PERIOD:     rdata_q <= {16'h0000, period_q};
                `MIN_PULSE_WIDTH_REG_DUTY_A:     rdata_q <= {16'h0000, duty_q[0]};
                `MIN_PULSE_WIDTH_REG_DUTY_B:     rdata_q <= {16'h0000, duty_q[1]};
                `MIN_PULSE_WIDTH_REG_DUTY_C:     rdata_q <= {16'h0000, duty_q[2]};
                `MIN_PULSE_WIDTH_REG_DEAD:       rdata_q <= {22'h0, dead_q};
                `MIN_PULSE_WIDTH_REG_MINPW:      rdata_q <= {22'h0, minpw_q};
                `MIN_PULSE_WIDTH_REG_SEG:        rdata_q <= {23'h0, seg_q};
                `MIN_PULSE_WIDTH_REG_STATUS:     rdata_q <= {24'h0, deleted_q,
                                                   (state_q == MIN_PULSE_WIDTH_RUN), half_q};
                `MIN_PULSE_WIDTH_REG_SEG_ACTIVE: rdata_q <= {23'h0, seg_sh_q};
                default:               rdata_q <= 32'h00000000;
            endcase
        end
    end

    // Software-written registers; unmapped writes are dropped.
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            ctrl_q   <= `MIN_PULSE_WIDTH_CTRL_RST;
            period_q <= `MIN_PULSE_WIDTH_PERIOD_RST;
            dead_q   <= `MIN_PULSE_WIDTH_DEAD_RST;
            minpw_q  <= `MIN_PULSE_WIDTH_MINPW_RST;
            seg_q    <= `MIN_PULSE_WIDTH_SEG_RST;
            for (int i = 0; i < 3; i++) begin
                duty_q[i] <= `MIN_PULSE_WIDTH_DUTY_RST;
            end
        end else if (wr_take) begin
            case (avs_address)
                `MIN_PULSE_WIDTH_REG_CTRL:
                    ctrl_q <= 2'(be_merge({30'h0, ctrl_q}, avs_writedata, avs_byteenable));
                `MIN_PULSE_WIDTH_REG_PERIOD:
                    period_q <= 16'(be_merge({16'h0, period_q}, avs_writedata, avs_byteenable));
                `MIN_PULSE_WIDTH_REG_DUTY_A:
                    duty_q[0] <= 16'(be_merge({16'h0, duty_q[0]}, avs_writedata, avs_byteenable));
                `MIN_PULSE_WIDTH_REG_DUTY_B:
                    duty_q[1] <= 16'(be_merge({16'h0, duty_q[1]}, avs_writedata, avs_byteenable));
                `MIN_PULSE_WIDTH_REG_DUTY_C:
                    duty_q[2] <= 16'(be_merge({16'h0, duty_q[2]}, avs_writedata, avs_byteenable));
                `MIN_PULSE_WIDTH_REG_DEAD:
                    dead_q <= 10'(be_merge({22'h0, dead_q}, avs_writedata, avs_byteenable));
                `MIN_PULSE_WIDTH_REG_MINPW:
                    minpw_q <= 10'(be_merge({22'h0, minpw_q}, avs_writedata, avs_byteenable));
                `MIN_PULSE_WIDTH_REG_SEG:
                    seg_q <= 9'(be_merge({23'h0, seg_q}, avs_writedata, avs_byteenable));
                default: begin
                end
            endcase
        end
    end

    assign run_start = (state_q == MIN_PULSE_WIDTH_IDLE) && ctrl_q[`MIN_PULSE_WIDTH_CTRL_ENABLE_BIT] &&
                       (period_q != 16'h0000);
    assign half_end  = (state_q == MIN_PULSE_WIDTH_RUN) && (cnt_q == 16'(period_sh_q - 16'h0001));
    // A new half latches only at period start, or every half in double update mode.
    assign latch_now = run_start ||
                       (half_end && ctrl_q[`MIN_PULSE_WIDTH_CTRL_ENABLE_BIT] &&
                        (half_q || ctrl_q[`MIN_PULSE_WIDTH_CTRL_DOUBLE_BIT]));

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            state_q <= MIN_PULSE_WIDTH_IDLE;
            cnt_q   <= 16'h0000;
            half_q  <= 1'b0;
        end else begin
            case (state_q)
                MIN_PULSE_WIDTH_IDLE: begin
                    cnt_q  <= 16'h0000;
                    half_q <= 1'b0;
                    if (run_start) begin
                        state_q <= MIN_PULSE_WIDTH_RUN;
                    end
                end
                MIN_PULSE_WIDTH_RUN: begin
                    if (half_end) begin
                        cnt_q  <= 16'h0000;
                        half_q <= ~half_q;
                        // Stopping waits for the next half boundary, mid-period included, so a centred high pulse can end at its centre.
                        if (!ctrl_q[`MIN_PULSE_WIDTH_CTRL_ENABLE_BIT]) begin
                            state_q <= MIN_PULSE_WIDTH_IDLE;
                        end
                    end else begin
                        cnt_q <= 16'(cnt_q + 16'h0001);
                    end
                end
                default: state_q <= MIN_PULSE_WIDTH_IDLE;
            endcase
        end
    end

    // In single update mode the first-half values carry into the second half.
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            period_sh_q <= `MIN_PULSE_WIDTH_PERIOD_RST;
            dead_sh_q   <= `MIN_PULSE_WIDTH_DEAD_RST;
            minpw_sh_q  <= `MIN_PULSE_WIDTH_MINPW_RST;
            seg_sh_q    <= `MIN_PULSE_WIDTH_SEG_RST;
            for (int i = 0; i < 3; i++) begin
                duty_sh_q[i] <= `MIN_PULSE_WIDTH_DUTY_RST;
            end
        end else if (latch_now) begin
            period_sh_q <= period_q;
            dead_sh_q   <= dead_q;
            minpw_sh_q  <= minpw_q;
            seg_sh_q    <= seg_q;
            for (int i = 0; i < 3; i++) begin
                duty_sh_q[i] <= duty_q[i];
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            sync_q <= 1'b0;
        end else begin
            sync_q <= latch_now;
        end
    end

    genvar p;
    generate
        for (p = 0; p < 3; p++) begin : g_phase
            logic [16:0] high_on;
            logic [16:0] low_on;
            logic        chk_on;
            logic        del_high;
            logic        del_low;
            // High sits around the period centre: end of first half, start of second.
            assign high_on  = sat_sub({1'b0, duty_sh_q[p]}, {7'h00, dead_sh_q}, 17'h0);
            assign low_on   = sat_sub({1'b0, period_sh_q}, {1'b0, duty_sh_q[p]},
                                      {7'h00, dead_sh_q});
            assign chk_on   = (minpw_sh_q != 10'h000);
            // Strict compare keeps a pulse exactly at the minimum.
            assign del_high = chk_on && (high_on < {7'h00, minpw_sh_q});
            assign del_low  = chk_on && !del_high && (low_on < {7'h00, minpw_sh_q});
            assign raw_high[p] = (state_q == MIN_PULSE_WIDTH_RUN) && !del_high &&
                                 (del_low || in_window({1'b0, cnt_q}, {1'b0, period_sh_q},
                                                       high_on, ~half_q));
            assign raw_low[p]  = (state_q == MIN_PULSE_WIDTH_RUN) && !del_low &&
                                 (del_high || in_window({1'b0, cnt_q}, {1'b0, period_sh_q},
                                                        low_on, half_q));
            assign deleted_d[2*p]     = (state_q == MIN_PULSE_WIDTH_RUN) && del_high;
            assign deleted_d[2*p + 1] = (state_q == MIN_PULSE_WIDTH_RUN) && del_low;
        end
    endgenerate

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            deleted_q <= 6'h00;
        end else begin
            deleted_q <= deleted_d;
        end
    end

    min_pulse_width_out_stage u_out (
        .clk_sys    (clk_sys),
        .nrst       (nrst),
        .raw_high   (raw_high),
        .raw_low    (raw_low),
        .seg        (seg_sh_q),
        .pin_high_q (pin_high_q),
        .pin_low_q  (pin_low_q)
    );

    assign avs_readdata      = rdata_q;
    assign avs_waitrequest   = wait_q;
    assign period_sync_pulse = sync_q;
    assign phase_a_high      = pin_high_q[0];
    assign phase_a_low       = pin_low_q[0];
    assign phase_b_high      = pin_high_q[1];
    assign phase_b_low       = pin_low_q[1];
    assign phase_c_high      = pin_high_q[2];
    assign phase_c_low       = pin_low_q[2];

endmodule

// File: testbench/min_pulse_width_assertions.sv
`timescale 1ns/1ps

module min_pulse_width_assertions (
    input wire logic        clk_sys,
    input wire logic        nrst,
    input wire logic [3:0]  avs_address,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0]  avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic        avs_waitrequest,
    input wire logic        period_sync_pulse,
    input wire logic        phase_a_high,
    input wire logic        phase_a_low,
    input wire logic        phase_b_high,
    input wire logic        phase_b_low,
    input wire logic        phase_c_high,
    input wire logic        phase_c_low
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);

    sequence req_s;
        (avs_read || avs_write) && avs_waitrequest;
    endsequence
    sequence ack_s;
        !avs_waitrequest ##1 avs_waitrequest;
    endsequence
    sequence rd_done_s;
        avs_read && !avs_waitrequest;
    endsequence

    a_bus_answer: assert property (req_s |=> ack_s)
        else $error("waitrequest did not answer in one cycle");
    a_bus_idle: assert property (!(avs_read || avs_write) && avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest dropped without a request");
    a_sync_pulse: assert property (period_sync_pulse |=> !period_sync_pulse)
        else $error("sync pulse longer than one cycle");
    a_pair_a_excl: assert property (!(phase_a_high && phase_a_low))
        else $error("phase a pins both on");
    a_pair_b_excl: assert property (!(phase_b_high && phase_b_low))
        else $error("phase b pins both on");
    a_pair_c_excl: assert property (!(phase_c_high && phase_c_low))
        else $error("phase c pins both on");
    a_unmapped_zero: assert property (rd_done_s and avs_address > 4'h9 |-> avs_readdata == 32'h0)
        else $error("unmapped read not zero");
    a_seg_width: assert property (rd_done_s and avs_address == 4'h7 |-> avs_readdata[31:9] == 23'h0)
        else $error("segment register wider than nine bits");
    a_reset_quiet: assert property (disable iff (1'b0) !nrst |=> avs_waitrequest && !period_sync_pulse
        && !(phase_a_high || phase_a_low || phase_b_high || phase_b_low || phase_c_high || phase_c_low))
        else $error("outputs active after reset");
endmodule

// File: testbench/min_pulse_width_gate_model.sv
`timescale 1ns/1ps

// Counts on-cycles of each gate input over every window between sync pulses.
module min_pulse_width_gate_model (
    input  wire logic            clk_sys,
    input  wire logic            period_sync_pulse,
    input  wire logic            phase_a_high,
    input  wire logic            phase_a_low,
    input  wire logic            phase_b_high,
    input  wire logic            phase_b_low,
    input  wire logic            phase_c_high,
    input  wire logic            phase_c_low,
    output logic      [5:0][7:0] on_cnt,
    output logic      [7:0]      win_len
);
    logic [5:0]      pin;
    logic [5:0][7:0] run;
    logic [7:0]      len;

    assign pin = {phase_c_low, phase_c_high, phase_b_low, phase_b_high, phase_a_low, phase_a_high};

    initial begin
        run = '0;
        len = '0;
        on_cnt = '0;
        win_len = '0;
    end

    // A whole window is summed, so the pin register delay does not shift the totals.
    always @(posedge clk_sys) begin
        for (int i = 0; i < 6; i++) begin
            if (period_sync_pulse) begin
                on_cnt[i] <= run[i] + 8'(pin[i]);
                run[i] <= '0;
            end else begin
                run[i] <= run[i] + 8'(pin[i]);
            end
        end
        win_len <= period_sync_pulse ? len + 8'h01 : win_len;
        len <= period_sync_pulse ? 8'h00 : len + 8'h01;
    end
endmodule

// File: testbench/min_pulse_width_top_tb.sv
`timescale 1ns/1ps
`include "min_pulse_width_params.svh"

module min_pulse_width_top_tb;
    logic            clk_sys;
    logic            nrst;
    logic [3:0]      avs_address;
    logic            avs_read;
    logic            avs_write;
    logic [31:0]     avs_writedata;
    logic [31:0]     avs_readdata;
    logic            avs_waitrequest;
    logic            period_sync_pulse;
    logic            ah, al, bh, bl, ch, cl;
    logic [5:0][7:0] on_cnt;
    logic [7:0]      win_len;
    logic [31:0]     rd;
    int              err_total;
    int              checked;

    min_pulse_width_top dut_u (.clk_sys(clk_sys), .nrst(nrst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(4'hF), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .period_sync_pulse(period_sync_pulse), .phase_a_high(ah), .phase_a_low(al),
        .phase_b_high(bh), .phase_b_low(bl), .phase_c_high(ch), .phase_c_low(cl));

    min_pulse_width_gate_model gm_u (.clk_sys(clk_sys), .period_sync_pulse(period_sync_pulse),
        .phase_a_high(ah), .phase_a_low(al), .phase_b_high(bh), .phase_b_low(bl),
        .phase_c_high(ch), .phase_c_low(cl), .on_cnt(on_cnt), .win_len(win_len));

    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end

    task final_report;
        if (err_total == 0 && checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task chk_cnt(input logic [7:0] e [6]);
        for (int i = 0; i < 6; i++)
            chk({24'h0, on_cnt[i]}, {24'h0, e[i]});
    endtask

    task bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
        int n;
        @(posedge clk_sys);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 20);
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        if (n >= 20)
            err_total++;
    endtask

    task rd_chk(input logic [3:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask

    // Settings land only at a latch point, so three syncs give one clean window.
    task wait_sync(input int n);
        int k;
        repeat (n) begin
            k = 0;
            do begin
                @(posedge clk_sys);
                k++;
            end while (period_sync_pulse !== 1'b1 && k < 200);
            if (k >= 200)
                err_total++;
        end
        #1;
    endtask

    task do_reset;
        @(posedge clk_sys);
        nrst <= 1'b0;
        repeat (4) @(posedge clk_sys);
        nrst <= 1'b1;
        @(posedge clk_sys);
        #1;
        chk({26'h0, ah, al, bh, bl, ch, cl}, 32'h0);
        rd_chk(`MIN_PULSE_WIDTH_REG_SEG, 32'h0);
        rd_chk(`MIN_PULSE_WIDTH_REG_SEG_ACTIVE, 32'h0);
        rd_chk(`MIN_PULSE_WIDTH_REG_CTRL, 32'h0);
    endtask

    task t_regs;
        rd_chk(`MIN_PULSE_WIDTH_REG_MINPW, 32'h0);
        rd_chk(`MIN_PULSE_WIDTH_REG_DEAD, 32'h0);
        bus(1'b1, 4'hF, 32'hFFFF_FFFF);
        rd_chk(4'hF, 32'h0);
        bus(1'b1, `MIN_PULSE_WIDTH_REG_SEG, 32'hFFFF_FFFF);
        rd_chk(`MIN_PULSE_WIDTH_REG_SEG, 32'h1FF);
        bus(1'b1, `MIN_PULSE_WIDTH_REG_MINPW, 32'hFFFF);
        rd_chk(`MIN_PULSE_WIDTH_REG_MINPW, 32'h3FF);
        bus(1'b1, `MIN_PULSE_WIDTH_REG_DEAD, 32'hFFFF);
        rd_chk(`MIN_PULSE_WIDTH_REG_DEAD, 32'h3FF);
        bus(1'b1, `MIN_PULSE_WIDTH_REG_SEG, 32'h0);
        bus(1'b1, `MIN_PULSE_WIDTH_REG_MINPW, 32'h0);
    endtask

    task t_single;
        bus(1'b1, `MIN_PULSE_WIDTH_REG_PERIOD, 32'd20);
        bus(1'b1, `MIN_PULSE_WIDTH_REG_DUTY_A, 32'd8);
        bus(1'b1, `MIN_PULSE_WIDTH_REG_DUTY_B, 32'd12);
        bus(1'b1, `MIN_PULSE_WIDTH_REG_DUTY_C, 32'd5);
        bus(1'b1, `MIN_PULSE_WIDTH_REG_DEAD, 32'd2);
        bus(1'b1, `MIN_PULSE_WIDTH_REG_CTRL, 32'h1);
        wait_sync(3);
        chk({24'h0, win_len}, 32'd40);
        chk_cnt('{8'd12, 8'd20, 8'd20, 8'd12, 8'd6, 8'd26});
        bus(1'b1, `MIN_PULSE_WIDTH_REG_DUTY_A, 32'd9);
        wait_sync(3);
        chk_cnt('{8'd14, 8'd18, 8'd20, 8'd12, 8'd6, 8'd26});
    endtask

    task t_delete;
        bus(1'b1, `MIN_PULSE_WIDTH_REG_MINPW, 32'd3);
        wait_sync(3);
        chk_cnt('{8'd14, 8'd18, 8'd20, 8'd12, 8'd6, 8'd26});
        bus(1'b1, `MIN_PULSE_WIDTH_REG_MINPW, 32'd4);
        wait_sync(3);
        chk_cnt('{8'd14, 8'd18, 8'd20, 8'd12, 8'd0, 8'd40});
        bus(1'b1, `MIN_PULSE_WIDTH_REG_MINPW, 32'd0);
    endtask

    task t_segment;
        logic [8:0] sv [4];
        logic [7:0] ev [4][6];
        sv = '{9'h100, 9'h0C0, 9'h013, 9'h110};
        ev[0] = '{8'd18, 8'd14, 8'd20, 8'd12, 8'd6, 8'd26};
        ev[1] = '{8'd14, 8'd18, 8'd12, 8'd20, 8'd26, 8'd6};
        ev[2] = '{8'd0, 8'd18, 8'd20, 8'd12, 8'd0, 8'd0};
        ev[3] = '{8'd0, 8'd14, 8'd20, 8'd12, 8'd6, 8'd26};
        wait_sync(1);
        bus(1'b1, `MIN_PULSE_WIDTH_REG_SEG, 32'h100);
        rd_chk(`MIN_PULSE_WIDTH_REG_SEG_ACTIVE, 32'h0);
        for (int i = 0; i < 4; i++) begin
            bus(1'b1, `MIN_PULSE_WIDTH_REG_SEG, {23'h0, sv[i]});
            wait_sync(3);
            rd_chk(`MIN_PULSE_WIDTH_REG_SEG_ACTIVE, {23'h0, sv[i]});
            chk_cnt(ev[i]);
        end
        bus(1'b1, `MIN_PULSE_WIDTH_REG_SEG, 32'h0);
    endtask

    task t_double;
        bus(1'b1, `MIN_PULSE_WIDTH_REG_CTRL, 32'h3);
        wait_sync(3);
        chk({24'h0, win_len}, 32'd20);
        chk_cnt('{8'd7, 8'd9, 8'd10, 8'd6, 8'd3, 8'd13});
        bus(1'b1, `MIN_PULSE_WIDTH_REG_DUTY_A, 32'd10);
        wait_sync(3);
        chk_cnt('{8'd8, 8'd8, 8'd10, 8'd6, 8'd3, 8'd13});
    endtask

    initial begin
        nrst = 1'b0;
        avs_address = 4'h0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
        err_total = 0;
        checked = 0;
        do_reset();
        t_regs();
        t_single();
        t_delete();
        t_segment();
        t_double();
        do_reset();
        final_report();
    end

    initial begin
        #3_000_000;
        err_total++;
        final_report();
    end
endmodule

bind min_pulse_width_top min_pulse_width_assertions chk_u (.clk_sys(clk_sys), .nrst(nrst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .period_sync_pulse(period_sync_pulse), .phase_a_high(phase_a_high),
    .phase_a_low(phase_a_low), .phase_b_high(phase_b_high), .phase_b_low(phase_b_low),
    .phase_c_high(phase_c_high), .phase_c_low(phase_c_low));
